// ---- design/tdtg_pkg.sv ----
package tdtg_pkg;

    // ----------------
    // Bus and counter widths
    // ----------------
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 24;
    localparam int CNT_W      = 16;
    localparam int NUM_CHAN   = 3;
    localparam int PIN_SEL_W  = 2;
    localparam int CODE_W     = 4;
    localparam int CHAN_SEL_W = 2;

    // ----------------
    // Register offsets
    // ----------------
    localparam logic [REG_ADDR_W-1:0] ADDR_TX_DRIVE_CONTROL   = 8'h79;
    localparam logic [REG_ADDR_W-1:0] ADDR_TX_PIN_SELECT      = 8'h7a;
    localparam logic [REG_ADDR_W-1:0] ADDR_TG_FRAME_CONTROL   = 8'h80;
    localparam logic [REG_ADDR_W-1:0] ADDR_DATAPATH_RST_START = 8'h83;
    localparam logic [REG_ADDR_W-1:0] ADDR_DATAPATH_RST_END   = 8'h84;

    // ----------------
    // Reset values and writable-bit masks
    // ----------------
    localparam logic [REG_DATA_W-1:0] RST_TX_DRIVE_CONTROL   = 24'h000001;
    localparam logic [REG_DATA_W-1:0] RST_TX_PIN_SELECT      = 24'h000000;
    localparam logic [REG_DATA_W-1:0] RST_TG_FRAME_CONTROL   = 24'h004e1e;
    localparam logic [REG_DATA_W-1:0] RST_DATAPATH_RST_START = 24'h0000d0;
    localparam logic [REG_DATA_W-1:0] RST_DATAPATH_RST_END   = 24'h0000d8;
    localparam logic [REG_DATA_W-1:0] MASK_TX_DRIVE_CONTROL  = 24'h081f1d;
    localparam logic [REG_DATA_W-1:0] MASK_TX_PIN_SELECT     = 24'h00003f;
    localparam logic [REG_DATA_W-1:0] MASK_TG_FRAME_CONTROL  = 24'h81ffff;
    localparam logic [REG_DATA_W-1:0] MASK_DATAPATH_RST      = 24'h00ffff;

    // ----------------
    // Field positions
    // ----------------
    localparam int DRIVER_PD_BIT     = 19;
    localparam int BIAS_PD_BIT       = 12;
    localparam int BIAS_CODE_LSB     = 8;
    localparam int ALL_BIAS_BIT      = 4;
    localparam int FOLLOW_BIT        = 3;
    localparam int INV_CLK_EN_BIT    = 2;
    localparam int TRUE_CLK_EN_BIT   = 0;
    localparam int CHAN0_SEL_LSB     = 4;
    localparam int CHAN1_SEL_LSB     = 0;
    localparam int CHAN2_SEL_LSB     = 2;
    localparam int OVERRIDE_BIT      = 23;
    localparam int SUBFRAME_CNT_LSB  = 1;
    localparam int TG_ENABLE_BIT     = 0;
    localparam int RST_POS_LSB       = 0;

    // ----------------
    // Pin selector codes and channel numbers
    // ----------------
    localparam logic [PIN_SEL_W-1:0]  PIN_TRUE_CLK = 2'h0;
    localparam logic [PIN_SEL_W-1:0]  PIN_INV_CLK  = 2'h2;
    localparam logic [PIN_SEL_W-1:0]  PIN_HIGH     = 2'h3;
    localparam logic [CHAN_SEL_W-1:0] CHAN0        = 2'h0;
    localparam logic [CNT_W-1:0]      CNT_ZERO     = 16'h0000;
    localparam logic [CNT_W-1:0]      CNT_ONE      = 16'h0001;

    // ----------------
    // Types
    // ----------------
    typedef enum logic {TG_IDLE, TG_RUN} tdtg_state_type;

    typedef struct packed {
        logic             enable;
        logic             override;
        logic [CNT_W-1:0] subframe_count;
        logic [CNT_W-1:0] rst_begin;
        logic [CNT_W-1:0] rst_finish;
    } tdtg_tg_cfg_type;

    typedef struct packed {
        logic              driver_powerdown;
        logic              bias_current_powerdown;
        logic [CODE_W-1:0] bias_current_code;
        logic              all_channel_bias_enable;
        logic              chan1_follows_chan0;
        logic              inverted_mod_clock_enable;
        logic              true_mod_clock_enable;
    } tdtg_tx_cfg_type;

endpackage : tdtg_pkg

// ---- design/tdtg_timing_gen.sv ----
`timescale 1ns/10ps
module tdtg_timing_gen import tdtg_pkg::*; (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            reset,
    input  wire logic            clk_en,
    // Configuration
    input  wire tdtg_tg_cfg_type cfg,
    // Timing outputs
    output logic                 running,
    output logic                 subframe_start,
    output logic                 datapath_reset,
    output logic [CNT_W-1:0]     count
);

    // ----------------
    // Sub-frame counter and data-path reset window
    // ----------------
    tdtg_state_type   state_reg,  state_next;
    logic [CNT_W-1:0] count_reg,  count_next;
    logic             start_reg,  start_next;
    logic             rst_reg,    rst_next;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        start_next = 1'b0;
        rst_next   = 1'b0;
        unique case (state_reg)
            TG_IDLE: begin
                count_next = CNT_ZERO;
                if (cfg.enable) begin // RL11
                    state_next = TG_RUN;
                    start_next = 1'b1;
                end
            end
            TG_RUN: begin
                if (!cfg.enable) begin // RL11
                    state_next = TG_IDLE;
                    count_next = CNT_ZERO;
                end else if (count_reg >= cfg.subframe_count) begin // RL10 RL16
                    count_next = CNT_ZERO;
                    start_next = 1'b1;
                end else begin
                    count_next = count_reg + CNT_ONE; // RL16
                end
            end
        endcase
        if (state_next == TG_RUN) begin
            rst_next = (count_next >= cfg.rst_begin)      // RL12
                     && (count_next < cfg.rst_finish);    // RL13 RL15
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= TG_IDLE;
            count_reg <= CNT_ZERO;
            start_reg <= 1'b0;
            rst_reg   <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            count_reg <= count_next;
            start_reg <= start_next;
            rst_reg   <= rst_next;
        end
    end

    assign running        = (state_reg == TG_RUN);
    assign subframe_start = start_reg;
    assign datapath_reset = rst_reg;
    assign count          = count_reg;

endmodule : tdtg_timing_gen

// ---- design/tdtg_tx_drive.sv ----
// Summary of operation
// [RL1] Driver powerdown bit 19 powers driver down
// [RL2] Bias powerdown bit 12 stops dc bias
// [RL3] Bias current is half mA times code
// [RL4] All-channel bias enable applies when channel 0
// [RL5] Channel 1 may follow channel 0 enable
// [RL6] Inverted clock gated by bit 2
// [RL7] True clock gated by bit 0, reset one
// [RL8] Pin selectors: true, inverted, or constant one
// [RL9] Override bit 23 stops mask autoconfiguration
// [RL10] Sub-frame length set by count field
// [RL11] Timing generator runs only while enabled
// [RL12] Data-path reset starts at begin count
// [RL13] Reset pulse lasts finish minus begin clocks
// [RL14] Software writes zero to reserved fields
// [RL15] Data-path reset ends at finish count
// [RL16] Counter runs from zero, wraps after count
`timescale 1ns/10ps
module tdtg_tx_drive import tdtg_pkg::*; (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    // Register port
    input  wire logic [REG_ADDR_W-1:0] reg_addr,
    input  wire logic [REG_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [REG_DATA_W-1:0] reg_rdata,
    output logic                       reg_rvalid,
    // Modulation clock and sequencer inputs
    input  wire logic                  mod_clock_in,
    input  wire logic                  illum_active,
    input  wire logic [CHAN_SEL_W-1:0] channel_select,
    // Transmit outputs
    output logic      [NUM_CHAN-1:0]   tx_pin,
    output logic      [NUM_CHAN-1:0]   chan_illum_enable,
    output logic      [NUM_CHAN-1:0]   chan_bias_enable,
    output logic                       driver_powerdown,
    output logic                       bias_current_powerdown,
    output logic      [CODE_W-1:0]     bias_current_code,
    // Timing generator outputs
    output logic                       mask_autoconfig_override,
    output logic                       timing_gen_running,
    output logic                       subframe_start,
    output logic                       datapath_reset,
    output logic      [CNT_W-1:0]      subframe_position
);

    // ----------------
    // Register file
    // ----------------
    logic [REG_DATA_W-1:0] drive_ctl_reg,  drive_ctl_next;
    logic [REG_DATA_W-1:0] pin_sel_reg,    pin_sel_next;
    logic [REG_DATA_W-1:0] frame_ctl_reg,  frame_ctl_next;
    logic [REG_DATA_W-1:0] rst_start_reg,  rst_start_next;
    logic [REG_DATA_W-1:0] rst_end_reg,    rst_end_next;
    logic [REG_DATA_W-1:0] rdata_reg,      rdata_next;
    logic                  rvalid_reg,     rvalid_next;

    always_comb begin
        drive_ctl_next = drive_ctl_reg;
        pin_sel_next   = pin_sel_reg;
        frame_ctl_next = frame_ctl_reg;
        rst_start_next = rst_start_reg;
        rst_end_next   = rst_end_reg;
        rdata_next     = rdata_reg;
        rvalid_next    = 1'b0;
        if (reg_write) begin
            unique case (reg_addr)
                ADDR_TX_DRIVE_CONTROL:
                    drive_ctl_next = reg_wdata & MASK_TX_DRIVE_CONTROL; // RL14
                ADDR_TX_PIN_SELECT:
                    pin_sel_next = reg_wdata & MASK_TX_PIN_SELECT; // RL14
                ADDR_TG_FRAME_CONTROL:
                    frame_ctl_next = reg_wdata & MASK_TG_FRAME_CONTROL; // RL14
                ADDR_DATAPATH_RST_START:
                    rst_start_next = reg_wdata & MASK_DATAPATH_RST; // RL14
                ADDR_DATAPATH_RST_END:
                    rst_end_next = reg_wdata & MASK_DATAPATH_RST; // RL14
                default: begin
                end
            endcase
        end
        if (reg_read) begin
            rvalid_next = 1'b1;
            unique case (reg_addr)
                ADDR_TX_DRIVE_CONTROL:   rdata_next = drive_ctl_reg;
                ADDR_TX_PIN_SELECT:      rdata_next = pin_sel_reg;
                ADDR_TG_FRAME_CONTROL:   rdata_next = frame_ctl_reg;
                ADDR_DATAPATH_RST_START: rdata_next = rst_start_reg;
                ADDR_DATAPATH_RST_END:   rdata_next = rst_end_reg;
                default:                 rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            drive_ctl_reg <= RST_TX_DRIVE_CONTROL; // RL7
            pin_sel_reg   <= RST_TX_PIN_SELECT;
            frame_ctl_reg <= RST_TG_FRAME_CONTROL;
            rst_start_reg <= RST_DATAPATH_RST_START;
            rst_end_reg   <= RST_DATAPATH_RST_END;
            rdata_reg     <= '0;
            rvalid_reg    <= 1'b0;
        end else if (clk_en) begin
            drive_ctl_reg <= drive_ctl_next;
            pin_sel_reg   <= pin_sel_next;
            frame_ctl_reg <= frame_ctl_next;
            rst_start_reg <= rst_start_next;
            rst_end_reg   <= rst_end_next;
            rdata_reg     <= rdata_next;
            rvalid_reg    <= rvalid_next;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    // ----------------
    // Field decode
    // ----------------
    tdtg_tx_cfg_type tx_cfg;
    tdtg_tg_cfg_type tg_cfg;

    always_comb begin
        tx_cfg.driver_powerdown          = drive_ctl_reg[DRIVER_PD_BIT];
        tx_cfg.bias_current_powerdown    = drive_ctl_reg[BIAS_PD_BIT];
        tx_cfg.bias_current_code         = drive_ctl_reg[BIAS_CODE_LSB +: CODE_W];
        tx_cfg.all_channel_bias_enable   = drive_ctl_reg[ALL_BIAS_BIT];
        tx_cfg.chan1_follows_chan0       = drive_ctl_reg[FOLLOW_BIT];
        tx_cfg.inverted_mod_clock_enable = drive_ctl_reg[INV_CLK_EN_BIT];
        tx_cfg.true_mod_clock_enable     = drive_ctl_reg[TRUE_CLK_EN_BIT];
        tg_cfg.enable         = frame_ctl_reg[TG_ENABLE_BIT];
        tg_cfg.override       = frame_ctl_reg[OVERRIDE_BIT];
        tg_cfg.subframe_count = frame_ctl_reg[SUBFRAME_CNT_LSB +: CNT_W];
        tg_cfg.rst_begin      = rst_start_reg[RST_POS_LSB +: CNT_W];
        tg_cfg.rst_finish     = rst_end_reg[RST_POS_LSB +: CNT_W];
    end

    // ----------------
    // Modulation clock synchroniser
    // ----------------
    logic sync1_reg, sync2_reg, sync3_reg, mod_reg;
    logic sync1_next, sync2_next, sync3_next, mod_next;

    always_comb begin
        sync1_next = mod_clock_in;
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        mod_next   = (sync2_reg == sync3_reg) ? sync3_reg : mod_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            mod_reg   <= 1'b0;
        end else if (clk_en) begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
            mod_reg   <= mod_next;
        end
    end

    // ----------------
    // Channel enables and pin multiplexers
    // ----------------
    localparam int SEL_LSB [NUM_CHAN] = '{CHAN0_SEL_LSB, CHAN1_SEL_LSB, CHAN2_SEL_LSB};

    logic                true_clk;
    logic                inv_clk;
    logic [NUM_CHAN-1:0] illum_next;
    logic [NUM_CHAN-1:0] bias_next;
    logic [NUM_CHAN-1:0] pin_next;
    logic [NUM_CHAN-1:0] illum_reg, bias_reg, pin_reg;
    logic                drv_pd_reg, bias_pd_reg, ovr_reg;
    logic [CODE_W-1:0]   code_reg;

    assign true_clk = mod_reg & tx_cfg.true_mod_clock_enable; // RL7
    assign inv_clk  = ~mod_reg & tx_cfg.inverted_mod_clock_enable; // RL6

    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        logic [PIN_SEL_W-1:0] sel;
        logic                 selected;
        logic                 base_en;
        assign sel      = pin_sel_reg[SEL_LSB[ch] +: PIN_SEL_W];
        assign selected = (channel_select == CHAN_SEL_W'(ch));
        assign base_en  = illum_active && selected && !tx_cfg.driver_powerdown; // RL1

        always_comb begin
            if (ch == 1 && tx_cfg.chan1_follows_chan0) begin
                illum_next[ch] = illum_active && (channel_select == CHAN0)
                               && !tx_cfg.driver_powerdown; // RL5
            end else begin
                illum_next[ch] = base_en; // RL5
            end
            bias_next[ch] = !tx_cfg.bias_current_powerdown // RL2
                          && (selected || (tx_cfg.all_channel_bias_enable
                          && channel_select == CHAN0)); // RL4
            unique case (sel)
                PIN_TRUE_CLK: pin_next[ch] = illum_next[ch] & true_clk; // RL8
                PIN_INV_CLK:  pin_next[ch] = illum_next[ch] & inv_clk; // RL8
                PIN_HIGH:     pin_next[ch] = illum_next[ch]; // RL8
                default:      pin_next[ch] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            illum_reg   <= '0;
            bias_reg    <= '0;
            pin_reg     <= '0;
            drv_pd_reg  <= 1'b0;
            bias_pd_reg <= 1'b0;
            code_reg    <= '0;
            ovr_reg     <= 1'b0;
        end else if (clk_en) begin
            illum_reg   <= illum_next;
            bias_reg    <= bias_next;
            pin_reg     <= pin_next;
            drv_pd_reg  <= tx_cfg.driver_powerdown; // RL1
            bias_pd_reg <= tx_cfg.bias_current_powerdown; // RL2
            code_reg    <= tx_cfg.bias_current_code; // RL3
            ovr_reg     <= tg_cfg.override; // RL9
        end
    end

    assign tx_pin                   = pin_reg;
    assign chan_illum_enable        = illum_reg;
    assign chan_bias_enable         = bias_reg;
    assign driver_powerdown         = drv_pd_reg;
    assign bias_current_powerdown   = bias_pd_reg;
    assign bias_current_code        = code_reg;
    assign mask_autoconfig_override = ovr_reg;

    // ----------------
    // Timing generator
    // ----------------
    tdtg_timing_gen u_timing_gen (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .clk_en         (clk_en),
        .cfg            (tg_cfg),
        .running        (timing_gen_running),
        .subframe_start (subframe_start),
        .datapath_reset (datapath_reset),
        .count          (subframe_position)
    );

endmodule : tdtg_tx_drive

// ---- sim/tdtg_tx_drive_props.sv ----
`timescale 1ns/10ps
module tdtg_props_chk import tdtg_pkg::*; (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire logic                  clk_en,
    // Register port
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [REG_DATA_W-1:0] reg_wdata,
    input wire logic                  reg_write,
    input wire logic                  reg_read,
    input wire logic                  reg_rvalid,
    // Outputs
    input wire logic [NUM_CHAN-1:0]   tx_pin,
    input wire logic [NUM_CHAN-1:0]   chan_illum_enable,
    input wire logic [NUM_CHAN-1:0]   chan_bias_enable,
    input wire logic                  driver_powerdown,
    input wire logic                  bias_current_powerdown,
    input wire logic [CODE_W-1:0]     bias_current_code,
    input wire logic                  mask_autoconfig_override,
    input wire logic                  timing_gen_running,
    input wire logic                  subframe_start,
    input wire logic                  datapath_reset,
    input wire logic [CNT_W-1:0]      subframe_position
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ----------------
    // Shadow registers, settled once three enabled edges follow a write
    // ----------------
    logic [REG_DATA_W-1:0] sh_tx, sh_pin, sh_fc, sh_beg, sh_fin;
    logic [1:0]            quiet;
    logic                  take;
    logic                  settled;
    assign take    = clk_en && reg_write;
    assign settled = quiet == 2'h3;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sh_tx  <= RST_TX_DRIVE_CONTROL;
            sh_pin <= RST_TX_PIN_SELECT;
            sh_fc  <= RST_TG_FRAME_CONTROL;
            sh_beg <= RST_DATAPATH_RST_START;
            sh_fin <= RST_DATAPATH_RST_END;
            quiet  <= 2'h0;
        end else begin
            if (take) quiet <= 2'h0;
            else if (clk_en && quiet != 2'h3) quiet <= quiet + 2'h1;
            if (take && reg_addr == ADDR_TX_DRIVE_CONTROL) sh_tx <= reg_wdata;
            if (take && reg_addr == ADDR_TX_PIN_SELECT) sh_pin <= reg_wdata;
            if (take && reg_addr == ADDR_TG_FRAME_CONTROL) sh_fc <= reg_wdata;
            if (take && reg_addr == ADDR_DATAPATH_RST_START) sh_beg <= reg_wdata;
            if (take && reg_addr == ADDR_DATAPATH_RST_END) sh_fin <= reg_wdata;
        end
    end
    a_rvalid_after_read: assert property (clk_en && reg_read |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_needs_read: assert property (reg_rvalid && $past(clk_en) |-> $past(reg_read))
        else $error("answer without read");
    a_power_fields_match: assert property (settled |->
        {driver_powerdown, bias_current_powerdown, bias_current_code} ==
        {sh_tx[DRIVER_PD_BIT], sh_tx[BIAS_PD_BIT], sh_tx[BIAS_CODE_LSB +: CODE_W]})
        else $error("power fields differ");
    a_illum_off_pd: assert property (settled && sh_tx[DRIVER_PD_BIT] |->
        chan_illum_enable == 3'h0) else $error("illumination while powered down");
    a_bias_off_pd: assert property (settled && sh_tx[BIAS_PD_BIT] |->
        chan_bias_enable == 3'h0) else $error("bias while powered down");
    a_override_match: assert property (settled |->
        mask_autoconfig_override == sh_fc[OVERRIDE_BIT]) else $error("override differs");
    a_pin_const_high: assert property (settled && sh_pin[5:0] == 6'h3f |->
        tx_pin == chan_illum_enable) else $error("constant pin wrong");
    a_inv_clock_off: assert property (settled && sh_pin[5:4] == PIN_INV_CLK &&
        !sh_tx[INV_CLK_EN_BIT] |-> !tx_pin[0]) else $error("inverted clock not gated");
    a_start_at_zero: assert property (subframe_start |->
        timing_gen_running && subframe_position == CNT_ZERO) else $error("start off zero");
    a_position_steps: assert property (timing_gen_running && $past(timing_gen_running) &&
        $past(clk_en) && subframe_position != CNT_ZERO |->
        subframe_position == $past(subframe_position) + CNT_ONE) else $error("count skipped");
    a_frame_length: assert property (settled && subframe_start && $past(clk_en) &&
        $past(timing_gen_running) |-> $past(subframe_position) == sh_fc[16:1])
        else $error("frame length wrong");
    a_reset_window: assert property (settled && timing_gen_running |->
        datapath_reset == (subframe_position >= sh_beg[15:0] && subframe_position < sh_fin[15:0]))
        else $error("reset pulse misplaced");
    a_stop_when_off: assert property (settled && !sh_fc[TG_ENABLE_BIT] |->
        !timing_gen_running) else $error("generator runs while disabled");
    c_read: cover property (reg_rvalid);
    c_pulse: cover property ($rose(datapath_reset));
    c_frame: cover property (settled && subframe_start && $past(timing_gen_running));
endmodule : tdtg_props_chk

bind tdtg_tx_drive tdtg_props_chk u_chk (.ref_clk, .reset, .clk_en, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rvalid, .tx_pin, .chan_illum_enable, .chan_bias_enable,
    .driver_powerdown, .bias_current_powerdown, .bias_current_code, .mask_autoconfig_override,
    .timing_gen_running, .subframe_start, .datapath_reset, .subframe_position);

// ---- sim/test_tof_tx_drive_and_timing_gen.sv ----
`timescale 1ns/10ps
module test_tof_tx_drive_and_timing_gen import tdtg_pkg::*; ();
    logic                  ref_clk, reset, clk_en, reg_write, reg_read, reg_rvalid;
    logic                  mod_clock_in, illum_active, driver_powerdown, bias_current_powerdown;
    logic                  mask_autoconfig_override, timing_gen_running, subframe_start;
    logic                  datapath_reset;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [REG_DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic [CHAN_SEL_W-1:0] channel_select;
    logic [NUM_CHAN-1:0]   tx_pin, chan_illum_enable, chan_bias_enable;
    logic [CODE_W-1:0]     bias_current_code;
    logic [CNT_W-1:0]      subframe_position, p;
    int                    n_mismatch, tests_run, cycles, seed, n, nd;
    logic [7:0]  addrs [6] = '{8'h79, 8'h7a, 8'h80, 8'h83, 8'h84, 8'h81};
    logic [23:0] rsts [6]  = '{24'h000001, 24'h0, 24'h004e1e, 24'h0000d0, 24'h0000d8, 24'h0};
    logic [23:0] txv [4]   = '{24'h000001, 24'h000019, 24'h000019, 24'h081019};
    logic [1:0]  csel [4]  = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic [5:0]  expc [4]  = '{6'h09, 6'h1f, 6'h02, 6'h00};
    logic [23:0] pinv [5]  = '{24'h3f, 24'h20, 24'h20, 24'h00, 24'h00};
    logic [23:0] pctl [5]  = '{24'h01, 24'h01, 24'h05, 24'h00, 24'h01};
    logic [23:0] msk [5]   = '{MASK_TX_DRIVE_CONTROL, MASK_TX_PIN_SELECT,
        MASK_TG_FRAME_CONTROL, MASK_DATAPATH_RST, MASK_DATAPATH_RST};

    tdtg_tx_drive uut (.ref_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .reg_rvalid, .mod_clock_in, .illum_active, .channel_select, .tx_pin,
        .chan_illum_enable, .chan_bias_enable, .driver_powerdown, .bias_current_powerdown,
        .bias_current_code, .mask_autoconfig_override, .timing_gen_running, .subframe_start,
        .datapath_reset, .subframe_position);

    // ----------------
    // Clock, modulation source and timeout
    // ----------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) #1 if (cycles[0]) mod_clock_in <= ~mod_clock_in;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ----------------
    // Tasks and expectations
    // ----------------
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [23:0] v);
        step(1);
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1'b1;
        step(1);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [23:0] exp);
        step(1);
        reg_addr = a;
        reg_read = 1'b1;
        step(1);
        reg_read = 1'b0;
        chk({23'h0, reg_rvalid}, 24'h1);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic end_test(input string name);
        $display("test %s done, %0d compares", name, tests_run);
    endtask : end_test
    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // Pin behaviour: 0 never high, 1 toggles, 2 always high
    function automatic logic [23:0] pin_kind(input logic [23:0] pin, input logic [23:0] ctl);
        if (pin[5:4] == 2'h3) return 24'h2;
        if (pin[5:4] == 2'h2) return {23'h0, ctl[2]};
        return {23'h0, ctl[0]};
    endfunction : pin_kind

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        seed = 15182;
        {reset, clk_en, reg_write, reg_read, mod_clock_in, illum_active} = 6'b110000;
        {reg_addr, reg_wdata, channel_select} = '0;
        step(12);
        reset = 1'b0;
        for (int i = 0; i < 6; i++) rd(addrs[i], rsts[i]);
        end_test("reset values");
        for (int i = 0; i < 5; i++) begin
            d = 24'($random(seed)) & msk[i];
            if (i == 1) d[5:0] = d[5:0] | 6'h2a;
            if (i == 2) d[0] = 1'b0;
            wr(addrs[i], d);
            rd(addrs[i], d);
        end
        end_test("readback");
        for (int i = 0; i < 4; i++) begin
            d = 24'($random(seed)) & MASK_TX_DRIVE_CONTROL;
            if (i == 0) d = MASK_TX_DRIVE_CONTROL;
            wr(ADDR_TX_DRIVE_CONTROL, d);
            step(1);
            chk({driver_powerdown, bias_current_powerdown, bias_current_code}, {d[19], d[12:8]});
        end
        end_test("power fields");
        illum_active = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_TX_DRIVE_CONTROL, txv[i]);
            channel_select = csel[i];
            step(2);
            chk({chan_illum_enable, chan_bias_enable}, expc[i]);
        end
        channel_select = 2'h0;
        end_test("channels");
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_TX_PIN_SELECT, pinv[i]);
            wr(ADDR_TX_DRIVE_CONTROL, pctl[i]);
            step(6);
            n = 0;
            repeat (8) begin
                n += int'(tx_pin[0] === 1'b1);
                step(1);
            end
            chk((n == 0) ? 24'h0 : (n == 8) ? 24'h2 : 24'h1, pin_kind(pinv[i], pctl[i]));
        end
        end_test("pin codes");
        wr(ADDR_DATAPATH_RST_START, 24'h3);
        wr(ADDR_DATAPATH_RST_END, 24'h7);
        d = 24'h800013;
        wr(ADDR_TG_FRAME_CONTROL, d);
        step(1);
        chk({23'h0, mask_autoconfig_override}, 24'h1);
        n = 0;
        while (subframe_start !== 1'b1 && n < 50) begin
            step(1);
            n++;
        end
        n = 0;
        nd = 0;
        p = 16'hffff;
        do begin
            step(1);
            n++;
            if (datapath_reset === 1'b1) nd++;
            if (datapath_reset === 1'b1 && p == 16'hffff) p = subframe_position;
        end while (subframe_start !== 1'b1 && n < 50);
        chk(24'(n), d[16:1] + 24'h1);
        chk(24'(nd), 24'h7 - 24'h3);
        chk(p, 24'h3);
        clk_en = 1'b0;
        p = subframe_position;
        step(5);
        chk(subframe_position, p);
        clk_en = 1'b1;
        step(25);
        wr(ADDR_TG_FRAME_CONTROL, 24'h000012);
        step(1);
        chk({23'h0, timing_gen_running}, 24'h0);
        chk({23'h0, mask_autoconfig_override}, 24'h0);
        end_test("timing generator");
        final_report();
    end
endmodule : test_tof_tx_drive_and_timing_gen
